// ===== hdl/i2c_bit_level.sv
// Purpose: Bit-level two-wire interface with filtering, stretching and auto clock pulse
// Assumes: CPU accesses one SFR byte per cycle; bus pins are open drain
// Notes: Received bits also pass a small FIFO for software that prefers a stream
`timescale 1ns/1ns
`include "i2c_bit_map.svh"

module i2c_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic vld;
    logic [WIDTH-1:0] dout;
  } fifo_state_t;
  fifo_state_t st, next_st;
  logic push, pop;

  // Handshake terms
  always_comb begin
    in_ready = (st.cnt != (AW+1)'(DEPTH));
    out_valid = st.vld;
    out_data = st.dout;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
  end

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    // Drain side registered from the updated count and pointer
    next_st.vld = (next_st.cnt != '0);
    next_st.dout = next_st.mem[next_st.rp];
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module i2c_bit_level (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // SFR access
  input wire logic SFR_RD,
  input wire logic SFR_WR,
  input wire logic SFR_BIT_OP,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Interrupt enables and request
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic SERIAL_IRQ_ENABLE,
  output logic IRQ,
  // Bus pins
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Received bit stream
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RX_DATA
);
  typedef struct packed {
    // Synchronisers and line filters
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [3:0] scl_cnt;
    logic [3:0] sda_cnt;
    logic scl_f;
    logic sda_f;
    // Software-visible latches and flags
    logic data_out_latch;
    logic clock_out_drive;
    logic filtered_data_in;
    logic clock_rise_flag;
    logic bus_busy_flag;
    logic read_bit_done;
    logic write_bit_done;
    logic hold_control_bit;
    logic interface_enable;
    // Bit sequencing
    logic start_flag;
    logic start_seen;
    logic stretch;
    logic arb_lost;
    logic cond_seen;
    // Auto pulse sequencer
    i2c_bit_pkg::pulse_state_t pstate;
    logic [6:0] pcnt;
    // Registered outputs
    logic [7:0] rdata;
    logic irq;
    i2c_bit_pkg::line_drive_t drive;
    logic rx_push;
  } blk_state_t;
  // Present and next state
  blk_state_t s, next_s;
  i2c_bit_pkg::sfr_req_t req;
  logic fifo_valid, fifo_data;
  // Decoded events of this cycle
  logic scl_rise, scl_fall, start_cond, stop_cond, bit_acc, ctrl_wr, irq_wr;

  // Bundle the bus request
  always_comb begin
    req.rd = SFR_RD;
    req.wr = SFR_WR;
    req.addr = SFR_ADDR;
    req.wdata = SFR_WDATA;
  end

  // Edges and conditions on filtered lines
  always_comb begin
    scl_rise = (s.scl_cnt == 4'(`FILTER_CYC)) && !s.scl_f && s.scl_sync[1];
    scl_fall = (s.scl_cnt == 4'(`FILTER_CYC)) && s.scl_f && !s.scl_sync[1];
    start_cond = s.scl_f && s.sda_f && (s.sda_cnt == 4'(`FILTER_CYC)) && !s.sda_sync[1];
    stop_cond = s.scl_f && !s.sda_f && (s.sda_cnt == 4'(`FILTER_CYC)) && s.sda_sync[1];
    bit_acc = (req.rd || req.wr) && (req.addr == `ADDR_SINGLE_BIT) && !SFR_BIT_OP;
    ctrl_wr = req.wr && (req.addr == `ADDR_CTRL_STATUS);
    irq_wr = req.wr && (req.addr == `ADDR_START_IRQ);
  end

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.rx_push = 1'b0;
    // Two-stage synchronisers feed the filters only
    next_s.scl_sync = {s.scl_sync[0], SCL_IN};
    next_s.sda_sync = {s.sda_sync[0], SDA_IN};
    // Filter: new level must hold for the window before it is taken
    if (s.scl_sync[1] == s.scl_f) begin
      next_s.scl_cnt = '0;
    end else if (s.scl_cnt == 4'(`FILTER_CYC)) begin
      next_s.scl_f = s.scl_sync[1];
      next_s.scl_cnt = '0;
    end else begin
      next_s.scl_cnt = s.scl_cnt + 1'b1;
    end
    // Same filter on the data line
    if (s.sda_sync[1] == s.sda_f) begin
      next_s.sda_cnt = '0;
    end else if (s.sda_cnt == 4'(`FILTER_CYC)) begin
      next_s.sda_f = s.sda_sync[1];
      next_s.sda_cnt = '0;
    end else begin
      next_s.sda_cnt = s.sda_cnt + 1'b1;
    end
    // Bus conditions
    if (start_cond) begin
      next_s.bus_busy_flag = 1'b1;
      next_s.start_seen = 1'b1;
      next_s.cond_seen = 1'b1;
    end
    if (stop_cond) begin
      next_s.bus_busy_flag = 1'b0;
      next_s.cond_seen = 1'b1;
      next_s.start_seen = 1'b0; // STOP cancels a pending start flag
    end
    // Register writes and access side effects
    if (ctrl_wr) begin
      next_s.data_out_latch = req.wdata[`BIT_DATA];
      next_s.clock_out_drive = req.wdata[`BIT_CLOCK];
      next_s.hold_control_bit = req.wdata[`BIT_HOLD];
      next_s.interface_enable = req.wdata[`BIT_ENABLE];
      // Zero on the rise bit clears the done flags too
      if (!req.wdata[`BIT_RISE]) begin
        next_s.clock_rise_flag = 1'b0;
        next_s.read_bit_done = 1'b0;
        next_s.write_bit_done = 1'b0;
      end
    end
    if (irq_wr && !req.wdata[`BIT_START_FLAG]) begin
      next_s.start_flag = 1'b0;
    end
    // Data register access starts a bit cycle
    if (bit_acc) begin
      if (req.wr) begin
        next_s.data_out_latch = req.wdata[`BIT_DATA];
      end
      next_s.start_flag = 1'b0;
      next_s.clock_rise_flag = 1'b0;
      next_s.read_bit_done = 1'b0;
      next_s.write_bit_done = 1'b0;
      next_s.stretch = 1'b0;
      next_s.arb_lost = 1'b0;
      next_s.cond_seen = 1'b0;
      if (!s.clock_out_drive) begin
        next_s.pstate = i2c_bit_pkg::PULSE_DELAY;
        next_s.pcnt = '0;
      end
    end
    // Line events win over clears in the same cycle
    if (scl_rise) begin
      next_s.filtered_data_in = s.sda_f;
      next_s.clock_rise_flag = 1'b1;
      next_s.rx_push = 1'b1;
      next_s.arb_lost = 1'b0;
      next_s.cond_seen = start_cond || stop_cond;
    end
    // Our released one over-ruled while the clock is high
    if (s.scl_f && s.data_out_latch && !s.sda_f && !start_cond && !stop_cond) begin
      next_s.arb_lost = 1'b1;
    end
    // Falling edge: start flag or bit completion
    if (scl_fall) begin
      if (s.start_seen) begin
        next_s.start_flag = 1'b1;
        next_s.stretch = 1'b1;
        next_s.start_seen = 1'b0;
      end else if (s.clock_rise_flag && !s.cond_seen && s.bus_busy_flag) begin
        next_s.read_bit_done = 1'b1;
        next_s.write_bit_done = !s.arb_lost;
      end
    end
    // Auto clock pulse sequencer
    case (s.pstate)
      // Wait out the rise delay
      i2c_bit_pkg::PULSE_DELAY: begin
        if (s.pcnt == 7'(`PULSE_DELAY_CYC - 1)) begin
          next_s.pstate = i2c_bit_pkg::PULSE_HIGH;
          next_s.pcnt = '0;
        end else begin
          next_s.pcnt = s.pcnt + 1'b1;
        end
      end
      // Hold high, pausing from the wait count on while the line is held low
      i2c_bit_pkg::PULSE_HIGH: begin
        if (s.pcnt == 7'(`PULSE_LEN_CYC - 1)) begin
          next_s.pstate = i2c_bit_pkg::PULSE_IDLE;
          next_s.pcnt = '0;
        end else if ((s.pcnt >= 7'(`PULSE_WAIT_CYC)) && !s.scl_f) begin
          next_s.pcnt = s.pcnt;
        end else begin
          next_s.pcnt = s.pcnt + 1'b1;
        end
      end
      // Idle
      default: begin
        next_s.pcnt = '0;
      end
    endcase
    // Read data mux
    next_s.rdata = 8'h00;
    if (req.addr == `ADDR_CTRL_STATUS) begin
      if (SFR_BIT_OP) begin
        next_s.rdata = {s.data_out_latch, s.clock_out_drive, 6'h00};
      end
      next_s.rdata[`BIT_DATA] = SFR_BIT_OP ? s.data_out_latch : s.filtered_data_in;
      next_s.rdata[`BIT_CLOCK] = SFR_BIT_OP ? s.clock_out_drive : s.scl_f;
      next_s.rdata[`BIT_RISE] = s.clock_rise_flag;
      next_s.rdata[`BIT_BUSY] = s.bus_busy_flag;
      next_s.rdata[`BIT_RDONE] = s.read_bit_done;
      next_s.rdata[`BIT_WDONE] = s.write_bit_done;
      next_s.rdata[`BIT_HOLD] = s.hold_control_bit;
      next_s.rdata[`BIT_ENABLE] = s.interface_enable;
    end else if (req.addr == `ADDR_SINGLE_BIT) begin
      next_s.rdata = {s.filtered_data_in, 7'h00};
    end else if (req.addr == `ADDR_START_IRQ) begin
      next_s.rdata = {s.start_flag, 7'h00};
    end
    // Interrupt request and pin drive
    next_s.irq = next_s.start_flag && GLOBAL_IRQ_ENABLE && SERIAL_IRQ_ENABLE;
    next_s.drive.sda_oe = !next_s.data_out_latch;
    next_s.drive.scl_oe = next_s.stretch || !(next_s.clock_out_drive || (next_s.pstate == i2c_bit_pkg::PULSE_HIGH));
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      s <= '0;
      s.scl_sync <= 2'b11;
      s.sda_sync <= 2'b11;
      s.scl_f <= 1'b1;
      s.sda_f <= 1'b1;
      s.data_out_latch <= `RESET_DATA_OUT;
      s.clock_out_drive <= `RESET_CLOCK_OUT;
      s.pstate <= i2c_bit_pkg::PULSE_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Received bit stream buffer
  i2c_bit_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) rx_fifo (
    .clk(CLOCK),
    .rst(SYS_RST),
    .in_valid(s.rx_push),
    .in_ready(),
    .in_data(s.filtered_data_in),
    .out_valid(fifo_valid),
    .out_ready(RX_READY),
    .out_data(fifo_data)
  );

  // Outputs straight from registers
  always_comb begin
    SFR_RDATA = s.rdata;
    IRQ = s.irq;
    SCL_OUT = 1'b0;
    SCL_OE = s.drive.scl_oe;
    SDA_OUT = 1'b0;
    SDA_OE = s.drive.sda_oe;
    RX_VALID = fifo_valid;
    RX_DATA = fifo_data;
  end
endmodule

// ===== hdl/i2c_bit_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the bit-level two-wire block
// Assumes: CPU special-function bus, one byte access per cycle, 10 MHz clock
// Notes: Counts are derived from oscillator periods; one clock is one oscillator period here
`ifndef I2C_BIT_MAP_SVH
`define I2C_BIT_MAP_SVH
`define ADDR_CTRL_STATUS 8'hD8
`define ADDR_SINGLE_BIT 8'hD9
`define ADDR_START_IRQ 8'hDA
`define BIT_DATA 7
`define BIT_CLOCK 6
`define BIT_RISE 5
`define BIT_BUSY 4
`define BIT_RDONE 3
`define BIT_WDONE 2
`define BIT_HOLD 1
`define BIT_ENABLE 0
`define BIT_START_FLAG 7
`define OSC_PERIOD_NS 100
`define XTAL_PERIOD_NS 100
`define PULSE_DELAY_XTAL 28
`define PULSE_LEN_XTAL 100
`define PULSE_WAIT_XTAL 20
`define FILTER_XTAL 8
`define PULSE_DELAY_CYC (((`PULSE_DELAY_XTAL * `XTAL_PERIOD_NS) + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS)
`define PULSE_LEN_CYC ((`PULSE_LEN_XTAL * `XTAL_PERIOD_NS) / `OSC_PERIOD_NS)
`define PULSE_WAIT_CYC (((`PULSE_WAIT_XTAL * `XTAL_PERIOD_NS) + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS)
`define FILTER_CYC (((`FILTER_XTAL * `XTAL_PERIOD_NS) + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS)
`define FIFO_DEPTH 16
`define FIFO_WIDTH 1
`define RESET_DATA_OUT 1'b1
`define RESET_CLOCK_OUT 1'b1
`endif

// ===== hdl/i2c_bit_pkg.sv
// Purpose: Types shared by the bit-level two-wire block
// Assumes: Constants come from the map header
// Notes: No constants live here
package i2c_bit_pkg;
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_DELAY = 2'b01,
    PULSE_HIGH = 2'b11
  } pulse_state_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } line_drive_t;
endpackage

// ===== tb/i2c_bit_chk.sv
// Purpose: Port assertions of the bit-level two-wire block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
`include "i2c_bit_map.svh"
module i2c_bit_chk (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // SFR access
  input wire logic SFR_RD,
  input wire logic SFR_WR,
  input wire logic SFR_BIT_OP,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Interrupt
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic SERIAL_IRQ_ENABLE,
  input wire logic IRQ,
  // Pins and stream
  input wire logic SCL_OE,
  input wire logic SDA_OE,
  input wire logic RX_VALID
);
  localparam int DLY = `PULSE_DELAY_CYC + 1;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Byte access of the data register, and plain reads
  wire logic d9 = (SFR_RD | SFR_WR) & ~SFR_BIT_OP & (SFR_ADDR == `ADDR_SINGLE_BIT);
  wire logic rd = SFR_RD & ~SFR_WR;
  a_irq_gated: assert property (IRQ |-> $past(GLOBAL_IRQ_ENABLE & SERIAL_IRQ_ENABLE))
    else $error("IRQ without both enables");
  a_reset_idle: assert property (disable iff (1'h0) SYS_RST |=> !IRQ && !SCL_OE && !SDA_OE && !RX_VALID)
    else $error("outputs not idle after reset");
  a_data_read_low: assert property (d9 && rd |=> SFR_RDATA[6:0] == 7'h00)
    else $error("data register low bits not zero");
  a_irq_read_low: assert property (rd && SFR_ADDR == `ADDR_START_IRQ |=> SFR_RDATA[6:0] == 7'h00)
    else $error("irq register low bits not zero");
  a_access_clears_irq: assert property (d9 |-> ##[1:2] !IRQ)
    else $error("data access left IRQ set");
  a_sda_release: assert property (d9 && SFR_WR && SFR_WDATA[7] |=> !SDA_OE)
    else $error("data one not released");
  a_sda_pull: assert property (SFR_WR && SFR_ADDR == `ADDR_CTRL_STATUS && !SFR_WDATA[7] |=> SDA_OE)
    else $error("data zero not driven");
  a_pulse_start: assert property (d9 && SCL_OE |-> ##[1:DLY] !SCL_OE)
    else $error("clock not released after access");
  a_pulse_min: assert property ($fell(SCL_OE) |-> !SCL_OE [*8])
    else $error("clock release too short");
  a_bitop_ignored: assert property (SFR_BIT_OP && rd && SFR_ADDR == `ADDR_SINGLE_BIT && SCL_OE |=> SCL_OE)
    else $error("bit access ended stretch");
endmodule
bind i2c_bit_level i2c_bit_chk u_chk (.*);

// ===== tb/i2c_far_dev.sv
// Purpose: Far bus device pulling the two open-drain lines
// Assumes: Lines have pull-ups; a pull of 1 holds a line low
// Notes: Link clock of 800 ns runs only inside frames
`timescale 1ns/1ns
module i2c_far_dev (
  // Open-drain pulls
  output logic scl_pull,
  output logic sda_pull
);
  logic link_clk = 1'h0;
  logic run = 1'h0;
  initial begin
    scl_pull = 1'h0;
    sda_pull = 1'h0;
  end
  // Link clock, still between frames
  always #400 if (run) link_clk = ~link_clk;
  // Two link periods per phase so the input filter keeps it
  task ph;
    repeat (2) @(posedge link_clk);
  endtask
  // Direct control for stretching and data setup
  task put(input logic s, input logic d);
    scl_pull = s;
    sda_pull = d;
  endtask
  // Data falls while clock high, then clock low
  task start;
    run = 1'h1;
    ph;
    sda_pull = 1'h1;
    ph;
    scl_pull = 1'h1;
    ph;
  endtask
  // One clock pulse; data moves a link period after the clock falls
  task clock_bit(input logic b);
    scl_pull = 1'h1;
    @(posedge link_clk);
    sda_pull = !b;
    ph;
    scl_pull = 1'h0;
    ph;
  endtask
  // Data low after clock low, then data rises while clock high
  task stop;
    scl_pull = 1'h1;
    @(posedge link_clk);
    sda_pull = 1'h1;
    ph;
    scl_pull = 1'h0;
    ph;
    sda_pull = 1'h0;
    ph;
    run = 1'h0;
  endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the bit-level two-wire block
// Assumes: 10 MHz clock, far device on both lines
// Notes: Expected stream bits are kept in a queue
`timescale 1ns/1ns
`include "i2c_bit_map.svh"
module tb_top;
  localparam logic [7:0] A_CS = `ADDR_CTRL_STATUS;
  localparam logic [7:0] A_SB = `ADDR_SINGLE_BIT;
  localparam logic [7:0] A_IR = `ADDR_START_IRQ;
  logic CLOCK = 1'h0;
  logic SYS_RST = 1'h1;
  logic SFR_RD = 1'h0;
  logic SFR_WR = 1'h0;
  logic SFR_BIT_OP = 1'h0;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [7:0] SFR_WDATA = 8'h00;
  logic GLOBAL_IRQ_ENABLE = 1'h1;
  logic SERIAL_IRQ_ENABLE = 1'h0;
  logic SCL_IN = 1'h1;
  logic SDA_IN = 1'h1;
  logic RX_READY = 1'h0;
  logic [7:0] SFR_RDATA, q;
  logic IRQ, SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, RX_VALID, RX_DATA, scl_pull, sda_pull, b;
  logic [31:0] seed = 32'h19F8CC43;
  logic bit_q[$];
  int error_cnt = 0;
  int total_checks = 0;
  int n, h;
  always #50 CLOCK = ~CLOCK;
  // Wired-AND of both parties' pulls
  always @(posedge CLOCK) begin
    SCL_IN <= !(SCL_OE | scl_pull);
    SDA_IN <= !(SDA_OE | sda_pull);
  end
  i2c_bit_level DUT (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .SFR_RD(SFR_RD), .SFR_WR(SFR_WR), .SFR_BIT_OP(SFR_BIT_OP),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .SERIAL_IRQ_ENABLE(SERIAL_IRQ_ENABLE), .IRQ(IRQ), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA));
  i2c_far_dev far (.scl_pull(scl_pull), .sda_pull(sda_pull));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h saw %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One SFR access; read data lands in q a cycle later
  task sfr(input logic w, input logic bo, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    SFR_RD <= !w;
    SFR_WR <= w;
    SFR_BIT_OP <= bo;
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    @(posedge CLOCK);
    SFR_RD <= 1'h0;
    SFR_WR <= 1'h0;
    SFR_BIT_OP <= 1'h0;
    @(negedge CLOCK);
    q = SFR_RDATA;
  endtask
  task rd(input logic [7:0] a);
    sfr(1'h0, 1'h0, a, 8'h00);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr(1'h1, 1'h0, a, d);
  endtask
  task cyc(input int k);
    repeat (k) @(negedge CLOCK);
  endtask
  // Bounded wait for the clock drive; n counts cycles
  task wt(input logic v);
    for (n = 0; SCL_OE !== v; n++) begin
      if (n > 900) begin
        error_cnt++;
        results;
      end
      @(negedge CLOCK);
    end
  endtask
  initial begin
    #9000000;
    error_cnt++;
    results;
  end
  initial begin
    repeat (20) @(posedge CLOCK);
    SYS_RST <= 1'h0;
    rd(A_CS);
    chk("cs_rst", q & 8'h7F, 8'h40);
    chk("pin_low", {SCL_OUT, SDA_OUT}, 8'h00);
    rd(A_IR);
    chk("ir_rst", q, 8'h00);
    rd(8'hD7);
    chk("unmapped", q, 8'h00);
    // START with serial interrupt masked
    far.start;
    wt(1'h1);
    cyc(3);
    chk("irq_mask", IRQ, 1'h0);
    rd(A_IR);
    chk("start", q, 8'h80);
    rd(A_CS);
    chk("busy", q & 8'h10, 8'h10);
    @(posedge CLOCK);
    SERIAL_IRQ_ENABLE <= 1'h1;
    cyc(3);
    chk("irq_on", IRQ, 1'h1);
    wr(A_IR, 8'hFF);
    rd(A_IR);
    chk("ir_one", q, 8'h80);
    wr(A_IR, 8'h00);
    cyc(2);
    chk("ir_clr", {IRQ, SCL_OE}, 8'h01);
    sfr(1'h0, 1'h1, A_SB, 8'h00);
    cyc(3);
    chk("bitop", SCL_OE, 1'h1);
    // Auto pulses with clock out low and random far data
    wr(A_CS, 8'h80);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      b = seed[0];
      far.put(1'h0, !b);
      wr(A_SB, 8'h80);
      wt(1'h0);
      chk("delay", n >= 27 && n <= 29, 1'h1);
      wt(1'h1);
      chk("length", n >= 99 && n <= 101, 1'h1);
      bit_q.push_back(b);
      cyc(15);
      rd(A_CS);
      chk("done", q, {b, 4'h7, b, 2'h0});
    end
    wr(A_CS, 8'h20);
    cyc(2);
    chk("sda_drv", SDA_OE, 1'h1);
    rd(A_CS);
    chk("rise_keep", q, {b, 4'h7, b, 2'h0});
    wr(A_CS, 8'h80);
    rd(A_CS);
    chk("rise_clr", q, {b, 7'h10});
    // Far side holds the clock low for 60 cycles
    far.put(1'h1, 1'h0);
    wr(A_SB, 8'h80);
    fork
      begin
        cyc(60);
        far.put(1'h0, 1'h0);
      end
    join_none
    wt(1'h0);
    rd(A_CS);
    chk("stalled", q & 8'h28, 8'h00);
    h = 0;
    repeat (400) begin
      @(negedge CLOCK);
      h += (SCL_OE === 1'h0 && SCL_IN === 1'h1);
    end
    chk("held", h >= 80, 1'h1);
    bit_q.push_back(1'h1);
    // Clock out high: release gives a rise, access gives no pulse
    wr(A_CS, 8'hC0);
    bit_q.push_back(1'h1);
    cyc(15);
    rd(A_SB);
    chk("sdi", q, 8'h80);
    h = 0;
    repeat (150) begin
      @(negedge CLOCK);
      h += (SCL_OE !== 1'h0);
    end
    chk("inhibit", h == 0, 1'h1);
    // Far clocking fills the stream while it stalls
    for (int i = 0; i < 13; i++) begin
      seed = lfsr(seed);
      far.clock_bit(seed[0]);
      if (bit_q.size() < 16) bit_q.push_back(seed[0]);
    end
    far.stop;
    cyc(20);
    rd(A_CS);
    chk("stop", q & 8'h10, 8'h00);
    @(posedge CLOCK);
    RX_READY <= 1'h1;
    n = 0;
    repeat (20) begin
      @(negedge CLOCK);
      if (RX_VALID === 1'h1) begin
        chk("rx_bit", RX_DATA, bit_q.size() > 0 ? bit_q.pop_front() : 1'hx);
        n++;
      end
    end
    chk("rx_cnt", n[7:0], 8'h10);
    results;
  end
endmodule
